/* logic/frm_map.vh */
`ifndef FRM_MAP_VH
`define FRM_MAP_VH
// register byte offsets
`define FRM_INTFRAC_OFS   8'h00
`define FRM_LOWFRAC_OFS   8'h04
`define FRM_REFDIV_OFS    8'h08
`define FRM_FUNC_OFS      8'h0c
`define FRM_CLOCK_OFS     8'h10
`define FRM_DEV_OFS       8'h14
`define FRM_STEP_OFS      8'h18
`define FRM_CTRL_OFS      8'h1c
`define FRM_STAT_OFS      8'h20
`define FRM_DIVRD_OFS     8'h24
// integer/fraction register fields
`define FRM_RAMP_ON_BIT   31
`define FRM_INT_MSB       26
`define FRM_INT_LSB       15
`define FRM_FMSB_MSB      14
`define FRM_FMSB_LSB      3
// low fraction register fields
`define FRM_FLSB_MSB      15
`define FRM_FLSB_LSB      3
`define FRM_PHASE_MSB     14
`define FRM_PHASE_LSB     3
// reference divider register fields
`define FRM_SLIP_EN_BIT   28
`define FRM_HOP1_MSB      14
`define FRM_HOP1_LSB      3
// function register fields
`define FRM_PD_POL_BIT    6
`define FRM_WAVE_MSB      11
`define FRM_WAVE_LSB      10
// clock register fields
`define FRM_CLKMODE_MSB   20
`define FRM_CLKMODE_LSB   19
`define FRM_HOP2_MSB      18
`define FRM_HOP2_LSB      7
// deviation register fields
`define FRM_DEVSEL_BIT    23
`define FRM_SHIFT_MSB     22
`define FRM_SHIFT_LSB     19
`define FRM_DEVW_MSB      18
`define FRM_DEVW_LSB      3
// step register field
`define FRM_STEPS_MSB     22
`define FRM_STEPS_LSB     3
// control register bits
`define FRM_FSK_EN_BIT    0
`define FRM_PSK_EN_BIT    1
`define FRM_SGL_TRI_BIT   2
// waveform codes
`define FRM_WAVE_CSAW     2'h0
`define FRM_WAVE_CTRI     2'h1
`define FRM_WAVE_SSAW     2'h2
`define FRM_WAVE_SRAMP    2'h3
// reset value of every register
`define FRM_REG_RST       32'h00000000
`endif

/* logic/frm_modulator.v */
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "frm_map.vh"
module frm_modulator #(
  parameter INT_W  = 12,   // integer field width
  parameter STEP_W = 20,   // step counter width
  parameter HOP_W  = 12    // hop divider width
) (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        mod_trigger,
  input  wire        slip_imminent,
  input  wire        slip_need_up,
  input  wire        target_passed,
  output reg  [40:0] divide_value,
  output reg  [11:0] phase_offset,
  output reg  [2:0]  slip_cells,
  output reg         slip_pump_up
);
  // one-hot ramp states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_UP   = 5'h02;
  localparam [4:0] ST_DOWN = 5'h04;
  localparam [4:0] ST_WRAP = 5'h08;
  localparam [4:0] ST_HOLD = 5'h10;
  // largest number of extra pump cells allowed at once
  localparam [2:0] CELL_MAX = 3'h7;

  // scaled deviation, sign extended to the divide width
  // a shift of up to 15 still fits the 41-bit divide word
  function [40:0] frm_scale;
    input [15:0] w;
    input [3:0]  s;
    begin
      frm_scale = {{25{w[15]}}, w} << s;
    end
  endfunction

  // divider value of zero counts as one
  // so that a cleared divider cannot stall the hop timer
  function [HOP_W-1:0] frm_nz;
    input [HOP_W-1:0] v;
    begin
      frm_nz = (v == {HOP_W{1'b0}}) ? {{(HOP_W-1){1'b0}}, 1'b1} : v;
    end
  endfunction

  // configuration registers
  // each register except control and deviation keeps the whole written word for readback
  reg  [31:0] intfrac_reg;   // integer/fraction
  reg  [31:0] lowfrac_reg;   // low fraction / phase
  reg  [31:0] refdiv_reg;    // reference divider
  reg  [31:0] func_reg;      // function
  reg  [31:0] clock_reg;     // clock
  reg  [22:3] dev_word0;     // first deviation word
  reg  [22:3] dev_word1;     // second deviation word
  reg         deviation_word_choice; // last select written
  reg  [31:0] step_reg;      // step
  reg  [2:0]  ctrl_reg;      // keying enables, single triangle

  // ramp and timer state
  // step_cnt counts hops within the current leg only
  reg  [4:0]        state;
  reg  [STEP_W-1:0] step_cnt;
  reg  [40:0]       ramp_ofs;
  reg  [HOP_W-1:0]  hop_cnt1;
  reg  [HOP_W-1:0]  hop_cnt2;
  reg               trig_meta;
  reg               trig_sync;
  reg               passed;   // target passed, unwinding

  // apb decode
  // pready is tied high, so every access phase lasts one cycle
  wire        wr_en  = psel & penable & pwrite;
  wire        rd_set = psel & ~penable & ~pwrite;
  reg         addr_ok;
  reg  [31:0] rd_mux;

  // register field views
  // divide word is the integer over 25 fraction bits, integer zero-extended
  wire [11:0] frac_hi  = intfrac_reg[`FRM_FMSB_MSB:`FRM_FMSB_LSB];
  wire [12:0] frac_lo  = lowfrac_reg[`FRM_FLSB_MSB:`FRM_FLSB_LSB];
  wire [INT_W-1:0] int_word =
    intfrac_reg[`FRM_INT_MSB:`FRM_INT_LSB];
  wire [24:0] frac_word = {frac_hi, frac_lo};
  wire [40:0] base_n = {{(16-INT_W){1'b0}}, int_word, frac_word};
  wire        ramp_on = intfrac_reg[`FRM_RAMP_ON_BIT];
  wire [1:0]  wave = func_reg[`FRM_WAVE_MSB:`FRM_WAVE_LSB];
  wire [22:3] deviation_word_choice_word =
    deviation_word_choice ? dev_word1 : dev_word0;
  wire [15:0] dev_w = deviation_word_choice_word[`FRM_DEVW_MSB:`FRM_DEVW_LSB];
  wire [3:0]  dev_s = deviation_word_choice_word[`FRM_SHIFT_MSB:`FRM_SHIFT_LSB];
  wire [40:0] dev_scaled = frm_scale(dev_w, dev_s);
  wire [STEP_W-1:0] steps =
    step_reg[`FRM_STEPS_LSB+STEP_W-1:`FRM_STEPS_LSB];
  wire [HOP_W-1:0] hop1 =
    frm_nz(refdiv_reg[`FRM_HOP1_MSB:`FRM_HOP1_LSB]);
  wire [HOP_W-1:0] hop2 =
    frm_nz(clock_reg[`FRM_HOP2_MSB:`FRM_HOP2_LSB]);
  wire        slip_en  = refdiv_reg[`FRM_SLIP_EN_BIT];
  wire [11:0] phase_val = lowfrac_reg[`FRM_PHASE_MSB:`FRM_PHASE_LSB];

  // hop expiry when both stages reach their terminal count
  // so a hop lands every first times second divider clocks
  wire hop_tick = (hop_cnt1 == hop1 - 1'b1) &
                  (hop_cnt2 == hop2 - 1'b1);
  // last step of the current up or down leg
  wire leg_done = (step_cnt + 1'b1 >= steps);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // address decode and read mux
  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h00000000;
    case (paddr)
      `FRM_INTFRAC_OFS: rd_mux = intfrac_reg;
      `FRM_LOWFRAC_OFS: rd_mux = lowfrac_reg;
      `FRM_REFDIV_OFS:  rd_mux = refdiv_reg;
      `FRM_FUNC_OFS:    rd_mux = func_reg;
      `FRM_CLOCK_OFS:   rd_mux = clock_reg;
      `FRM_DEV_OFS:     rd_mux = {8'h00, deviation_word_choice,
                                  deviation_word_choice_word, 3'h5};
      `FRM_STEP_OFS:    rd_mux = step_reg;
      `FRM_CTRL_OFS:    rd_mux = {29'h00000000, ctrl_reg};
      // status: unwind flag, cell count, one-hot state, step count
      `FRM_STAT_OFS:    rd_mux = {3'h0, passed, slip_cells,
                                  state, step_cnt};
      `FRM_DIVRD_OFS:   rd_mux = divide_value[40:9];
      default:          addr_ok = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  // and held until the next read setup, so the access edge sees it
  always @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (rd_set) begin
      prdata <= rd_mux;
    end
  end

  // register writes take effect at the access edge
  // read-only and unmapped offsets fall through and change nothing
  always @(posedge ref_clk) begin
    if (srst) begin
      intfrac_reg <= `FRM_REG_RST;
      lowfrac_reg <= `FRM_REG_RST;
      refdiv_reg  <= `FRM_REG_RST;
      func_reg    <= `FRM_REG_RST;
      clock_reg   <= `FRM_REG_RST;
      step_reg    <= `FRM_REG_RST;
      dev_word0   <= 20'h00000;
      dev_word1   <= 20'h00000;
      deviation_word_choice <= 1'b0;
      ctrl_reg    <= 3'h0;
    end else if (wr_en) begin
      case (paddr)
        `FRM_INTFRAC_OFS: intfrac_reg <= pwdata;
        `FRM_LOWFRAC_OFS: lowfrac_reg <= pwdata;
        `FRM_REFDIV_OFS:  refdiv_reg  <= pwdata;
        `FRM_FUNC_OFS:    func_reg    <= pwdata;
        `FRM_CLOCK_OFS:   clock_reg   <= pwdata;
        `FRM_STEP_OFS:    step_reg    <= pwdata;
        `FRM_CTRL_OFS:    ctrl_reg    <= pwdata[2:0];
        `FRM_DEV_OFS: begin
          // select bit steers which word is loaded and used
          deviation_word_choice <= pwdata[`FRM_DEVSEL_BIT];
          if (pwdata[`FRM_DEVSEL_BIT]) begin
            dev_word1 <= pwdata[22:3];
          end else begin
            dev_word0 <= pwdata[22:3];
          end
        end
        default: ;
      endcase
    end
  end

  // trigger pin two-stage synchroniser
  // only the second flop feeds the keying logic
  always @(posedge ref_clk) begin
    if (srst) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end else begin
      trig_meta <= mod_trigger;
      trig_sync <= trig_meta;
    end
  end

  // two-stage hop timer, free running while ramp runs
  // held at zero in idle so the first hop is one full period away
  always @(posedge ref_clk) begin
    if (srst || !ramp_on || state == ST_IDLE) begin
      hop_cnt1 <= {HOP_W{1'b0}};
      hop_cnt2 <= {HOP_W{1'b0}};
    end else if (hop_cnt1 == hop1 - 1'b1) begin
      hop_cnt1 <= {HOP_W{1'b0}};
      // second stage advances once per first-stage wrap
      if (hop_cnt2 == hop2 - 1'b1) begin
        hop_cnt2 <= {HOP_W{1'b0}};
      end else begin
        hop_cnt2 <= hop_cnt2 + 1'b1;
      end
    end else begin
      hop_cnt1 <= hop_cnt1 + 1'b1;
    end
  end

  // ramp waveform state machine
  // up and down legs each count the programmed steps; the wrap state
  // waits one more expiry before returning to the start value
  always @(posedge ref_clk) begin
    if (srst || !ramp_on) begin
      // disabling the ramp ends any waveform
      // and the output falls back to keying or the centre value
      state    <= ST_IDLE;
      step_cnt <= {STEP_W{1'b0}};
      ramp_ofs <= 41'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          // start from the programmed centre value
          state    <= ST_UP;
          step_cnt <= {STEP_W{1'b0}};
          ramp_ofs <= 41'h0;
        end
        ST_UP: begin
          // one scaled step per timer expiry
          if (hop_tick) begin
            ramp_ofs <= ramp_ofs + dev_scaled;
            step_cnt <= step_cnt + 1'b1;
            if (leg_done) begin
              step_cnt <= {STEP_W{1'b0}};
              case (wave)
                `FRM_WAVE_SRAMP: begin
                  // single triangle shares the ramp code
                  if (ctrl_reg[`FRM_SGL_TRI_BIT]) begin
                    state <= ST_DOWN;
                  end else begin
                    state <= ST_HOLD;
                  end
                end
                `FRM_WAVE_CTRI: state <= ST_DOWN;
                default:        state <= ST_WRAP;
              endcase
            end
          end
        end
        ST_DOWN: begin
          // falling leg mirrors the rising one
          if (hop_tick) begin
            ramp_ofs <= ramp_ofs - dev_scaled;
            step_cnt <= step_cnt + 1'b1;
            if (leg_done) begin
              step_cnt <= {STEP_W{1'b0}};
              if (wave == `FRM_WAVE_CTRI) begin
                state <= ST_UP;
              end else begin
                state <= ST_HOLD;
              end
            end
          end
        end
        ST_WRAP: begin
          // next expiry returns to the start value
          if (hop_tick) begin
            ramp_ofs <= 41'h0;
            if (wave == `FRM_WAVE_CSAW) begin
              state <= ST_UP;
            end else begin
              state <= ST_HOLD;
            end
          end
        end
        // single bursts park here until the ramp is disabled
        ST_HOLD: state <= ST_HOLD;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // divide value and phase outputs
  // a running ramp takes precedence over frequency keying
  always @(posedge ref_clk) begin
    if (srst) begin
      divide_value <= 41'h0;
      phase_offset <= 12'h000;
    end else begin
      if (ramp_on && state != ST_IDLE) begin
        divide_value <= base_n + ramp_ofs;
      end else if (ctrl_reg[`FRM_FSK_EN_BIT]) begin
        // keying around the centre value
        if (trig_sync) begin
          divide_value <= base_n + dev_scaled;
        end else begin
          divide_value <= base_n - dev_scaled;
        end
      end else begin
        divide_value <= base_n;
      end
      if (ctrl_reg[`FRM_PSK_EN_BIT]) begin
        // offset in 1/4096 turn, two's complement retards
        if (trig_sync) begin
          phase_offset <= phase_val;
        end else begin
          phase_offset <= 12'h000 - phase_val;
        end
      end else begin
        phase_offset <= 12'h000;
      end
    end
  end

  // extra charge pump cell control
  // an unwind request outranks a new slip warning
  // the cell count saturates at seven and never wraps
  always @(posedge ref_clk) begin
    if (srst || !slip_en) begin
      slip_cells   <= 3'h0;
      slip_pump_up <= 1'b0;
      passed       <= 1'b0;
    end else if (passed || target_passed) begin
      // unwind one cell per clock until none remain
      passed <= (slip_cells > 3'h1);
      if (slip_cells != 3'h0) begin
        slip_cells <= slip_cells - 1'b1;
      end
    end else if (slip_imminent && slip_cells != CELL_MAX) begin
      slip_cells   <= slip_cells + 1'b1;
      slip_pump_up <= slip_need_up;
    end
  end
endmodule // frm_modulator
`default_nettype wire

/* test/frm_host.sv */
`timescale 1ns/1ps
`default_nettype none
module frm_host (
  input  wire logic        ref_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel = 1'b0,
  output var  logic        penable = 1'b0,
  output var  logic        pwrite = 1'b0,
  output var  logic [7:0]  paddr = 8'h0,
  output var  logic [31:0] pwdata = 32'h0
);
  // one apb transfer: setup, access held until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;  // released data does not linger
  endtask
endmodule // frm_host
`default_nettype wire

/* test/frm_modulator_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module frm_modulator_chk (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mod_trigger,
  input wire logic        target_passed,
  input wire logic [40:0] divide_value,
  input wire logic [11:0] phase_offset,
  input wire logic [2:0]  slip_cells
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // bus idle and trigger steady long enough for the sync chain to settle
  sequence quiet_s;
    (!psel && $stable(mod_trigger)) [*6];
  endsequence
  // an unwind request while cells are active
  sequence unwind_s;
    target_passed && slip_cells != 3'h0;
  endsequence
  reset_clear_a: assert property ($fell(srst) |-> slip_cells == 3'h0 &&
    divide_value == 41'h0 && phase_offset == 12'h0) else $error("reset not clear");
  trig_settle_a: assert property (quiet_s |=> $stable(phase_offset))
    else $error("phase moved while quiet");
  cells_step_a: assert property (1'b1 |=>
    {1'b0, slip_cells} <= {1'b0, $past(slip_cells)} + 4'h1 &&
    {1'b0, slip_cells} + 4'h1 >= {1'b0, $past(slip_cells)}) else $error("cell jump");
  cells_cap_a: assert property (slip_cells == 3'h7 && !target_passed && !psel
    |=> slip_cells == 3'h7) else $error("cell count wrapped");
  unwind_step_a: assert property (unwind_s |=>
    slip_cells == $past(slip_cells) - 3'h1) else $error("unwind not single");
  unwind_done_a: assert property (target_passed |-> ##[0:7] slip_cells == 3'h0)
    else $error("unwind too slow");
  bad_addr_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("unmapped not refused");
  good_addr_a: assert property (psel && penable && paddr <= 8'h24 &&
    paddr[1:0] == 2'h0 |-> pready && !pslverr) else $error("mapped refused");
endmodule // frm_modulator_chk
bind frm_modulator frm_modulator_chk u_chk (.ref_clk, .srst, .psel, .penable,
  .paddr, .pready, .pslverr, .mod_trigger, .target_passed, .divide_value,
  .phase_offset, .slip_cells);
`default_nettype wire

/* test/frm_modulator_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "frm_map.vh"
module frm_modulator_tb;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        mod_trigger = 1'b0;
  logic        slip_imminent = 1'b0;
  logic        slip_need_up = 1'b0;
  logic        target_passed = 1'b0;
  wire         psel, penable, pwrite, pready, pslverr, slip_pump_up;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  wire  [40:0] divide_value;
  wire  [11:0] phase_offset;
  wire  [2:0]  slip_cells;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  // centre value and one scaled step of 0x100 shifted by 2
  logic [40:0] base = {4'h0, 12'h079, 12'h051, 13'h1d70};
  logic [40:0] dlt = 41'h400;
  always #50 ref_clk = ~ref_clk;
  frm_host u_host (.ref_clk, .prdata, .pready, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  frm_modulator dut (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mod_trigger, .slip_imminent, .slip_need_up,
    .target_passed, .divide_value, .phase_offset, .slip_cells, .slip_pump_up);
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [40:0] seen, input logic [40:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    u_host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic dev(input logic sel, input logic [15:0] word);
    wr(`FRM_DEV_OFS, {8'h0, sel, 4'h2, word, 3'h0});
  endtask
  task automatic intf(input logic on);
    wr(`FRM_INTFRAC_OFS, {on, 4'h0, 12'h079, 12'h051, 3'h0});
  endtask
  task automatic trig(input logic v);
    mod_trigger <= v;
    w(4);
  endtask
  task automatic t_base;
    wr(`FRM_LOWFRAC_OFS, {16'h0, 13'h1d70, 3'h0});
    intf(1'b0);
    w(3);
    chk("divide", divide_value, base);
    $display("end base");
  endtask
  task automatic t_fsk;
    dev(1'b1, 16'h0200);
    dev(1'b0, 16'hff00);
    wr(`FRM_CTRL_OFS, 32'h1);
    trig(1'b1);
    chk("fsk high", divide_value, base - dlt);
    trig(1'b0);
    chk("fsk low", divide_value, base + dlt);
    dev(1'b1, 16'h0200);
    w(3);
    chk("fsk word two", divide_value, base - (dlt << 1));
    $display("end fsk");
  endtask
  task automatic t_psk;
    wr(`FRM_CTRL_OFS, 32'h2);
    trig(1'b1);
    chk("phase up", {29'h0, phase_offset}, 41'hd70);
    trig(1'b0);
    chk("phase down", {29'h0, phase_offset}, 41'h290);
    $display("end psk");
  endtask
  // hop every nine clocks, two steps per ramp
  task automatic t_ramp(input logic [1:0] wave, input logic tri_on,
                        input logic [40:0] mid, input logic [40:0] fin);
    wr(`FRM_CTRL_OFS, {29'h0, tri_on, 2'h0});
    wr(`FRM_FUNC_OFS, {20'h0, wave, 3'h0, 1'b1, 6'h0});
    intf(1'b1);
    w(16);
    chk("ramp mid", divide_value, mid);
    w(34);
    chk("ramp end", divide_value, fin);
    intf(1'b0);
    $display("end ramp %0d", wave);
  endtask
  task automatic t_ramps;
    dev(1'b0, 16'h0100);
    wr(`FRM_REFDIV_OFS, {17'h0, 12'h003, 3'h0});
    wr(`FRM_CLOCK_OFS, {11'h0, 2'h3, 12'h003, 7'h0});
    wr(`FRM_STEP_OFS, {9'h0, 20'h00002, 3'h0});
    t_ramp(`FRM_WAVE_SRAMP, 1'b0, base + dlt, base + (dlt << 1));
    t_ramp(`FRM_WAVE_SSAW, 1'b0, base + dlt, base);
    t_ramp(`FRM_WAVE_SRAMP, 1'b1, base + dlt, base);
    t_ramp(`FRM_WAVE_CSAW, 1'b0, base + dlt, base + (dlt << 1));
    t_ramp(`FRM_WAVE_CTRI, 1'b0, base + dlt, base + dlt);
  endtask
  task automatic t_slip;
    slip_need_up <= 1'b1;
    slip_imminent <= 1'b1;
    w(3);
    slip_imminent <= 1'b0;
    w(2);
    chk("cells off", {38'h0, slip_cells}, 41'h0);
    wr(`FRM_REFDIV_OFS, {3'h0, 1'b1, 13'h0, 12'h003, 3'h0});
    slip_imminent <= 1'b1;
    w(9);
    slip_imminent <= 1'b0;
    w(2);
    chk("cells max", {38'h0, slip_cells}, 41'h7);
    chk("cells dir", {40'h0, slip_pump_up}, 41'h1);
    target_passed <= 1'b1;
    w(1);
    target_passed <= 1'b0;
    w(10);
    chk("cells none", {38'h0, slip_cells}, 41'h0);
    slip_need_up <= 1'b0;
    slip_imminent <= 1'b1;
    w(1);
    slip_imminent <= 1'b0;
    w(2);
    chk("cells one", {38'h0, slip_cells}, 41'h1);
    chk("cells dir down", {40'h0, slip_pump_up}, 41'h0);
    $display("end slip");
  endtask
  task automatic t_err;
    logic [31:0] rd;
    logic        er;
    u_host.xfer(1'b0, 8'h40, 32'h0, rd, er);
    chk("unmapped err", {40'h0, er}, 41'h1);
    chk("unmapped data", {9'h0, rd}, 41'h0);
    u_host.xfer(1'b0, `FRM_DIVRD_OFS, 32'h0, rd, er);
    chk("divide readback", {9'h0, rd}, {9'h0, base[40:9]});
    u_host.xfer(1'b0, `FRM_DEV_OFS, 32'h0, rd, er);
    chk("dev readback", {9'h0, rd}, {18'h0, 4'h2, 16'h0100, 3'h5});
    $display("end err");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    t_base;
    t_fsk;
    t_psk;
    t_ramps;
    t_slip;
    t_err;
    complete_run();
  end
endmodule // frm_modulator_tb
`default_nettype wire
